// ### card_pkg.sv
// Shared constants, modes and state types for the card host port ends
package card_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_TIME_NS = 1000;
  localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IREQ_PULSE_NS = 400;
  localparam int IREQ_PULSE_CYCLES = (IREQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_NS = 165;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_NS = 80;
  localparam int RECOV_CYCLES = (RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // ==========================================================
  // Synchroniser reset levels and chip select codes
  // Card inputs {oe_n, reg_n, dmack_n, iord_n, iowr_n, we_n, rst_pin}
  localparam logic [6:0] CARD_SYNC_INIT = 7'h7e;
  // Host inputs {ready_irq, wait_n, dmarq}
  localparam logic [2:0] HOST_SYNC_INIT = 3'h2;
  localparam logic [1:0] CS_IDLE = 2'h3;
  localparam logic [1:0] CS_SEL0 = 2'h2;

  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {MODE_MEM, MODE_IO, MODE_IDE} mode_t;
  typedef enum logic [1:0] {SPACE_NONE, SPACE_COMMON, SPACE_ATTR, SPACE_IO} space_t;
  typedef enum logic [1:0] {RS_POWER, RS_RUN, RS_HELD, RS_BUSY} rst_state_t;
  typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_ACK} dma_state_t;
  typedef enum logic [2:0] {CMD_MEM_RD, CMD_MEM_WR, CMD_ATTR_RD, CMD_ATTR_WR,
                            CMD_IO_RD, CMD_IO_WR} cmd_t;
  typedef enum logic [1:0] {H_IDLE, H_STROBE, H_RECOV} host_state_t;

  // ==========================================================
  // Module state
  typedef struct packed {
    logic ide;
    mode_t mode;
    rst_state_t rst;
    logic [CNT_W-1:0] rst_cnt;
    logic armed;
    logic irq_prev;
    logic [CNT_W-1:0] ireq_cnt;
    dma_state_t dma;
    logic ready_irq;
    logic wait_n;
    logic wait_oe;
    logic dmarq;
    logic dmarq_oe;
    logic data_oe;
    space_t space;
    logic dma_ack;
    logic card_rst;
  } card_state_t;

  localparam card_state_t CARD_RESET = '{ide: 1'b0, mode: MODE_MEM, rst: RS_POWER,
    rst_cnt: '0, armed: 1'b0, irq_prev: 1'b0, ireq_cnt: '0, dma: DMA_IDLE,
    ready_irq: 1'b0, wait_n: 1'b1, wait_oe: 1'b1, dmarq: 1'b0, dmarq_oe: 1'b0,
    data_oe: 1'b0, space: SPACE_NONE, dma_ack: 1'b0, card_rst: 1'b1};

  typedef struct packed {
    host_state_t hs;
    logic [CNT_W-1:0] cnt;
    logic oe_n;
    logic reg_n;
    logic we_n;
    logic iord_n;
    logic iowr_n;
    logic dmack_n;
    logic rst_pin;
    logic [1:0] cs_n;
    logic cmd_ready;
    logic done;
    logic dma_busy;
  } host_state_st_t;

  localparam host_state_st_t HOST_RESET = '{hs: H_IDLE, cnt: '0, oe_n: 1'b1,
    reg_n: 1'b1, we_n: 1'b1, iord_n: 1'b1, iowr_n: 1'b1, dmack_n: 1'b1,
    rst_pin: 1'b0, cs_n: CS_IDLE, cmd_ready: 1'b0, done: 1'b0, dma_busy: 1'b0};

endpackage : card_pkg

// ### card_port_if.sv
// Pin-level carrier between the card end and the host end
`timescale 1ns/10ps
interface card_port_if;
  // Host driven
  logic oe_n;
  logic reg_n;
  logic we_n;
  logic iord_n;
  logic iowr_n;
  logic dmack_n;
  logic rst_pin;
  logic [1:0] cs_n;
  // Card driven
  logic ready_irq;
  logic wait_n;
  logic wait_oe;
  logic dmarq;
  logic dmarq_oe;
  logic vs1_n;
  logic vs1_oe;
  logic vs2_oe;
  logic data_oe;

  modport card (
    input oe_n, reg_n, we_n, iord_n, iowr_n, dmack_n, rst_pin, cs_n,
    output ready_irq, wait_n, wait_oe, dmarq, dmarq_oe, vs1_n, vs1_oe, vs2_oe, data_oe
  );
  modport host (
    output oe_n, reg_n, we_n, iord_n, iowr_n, dmack_n, rst_pin, cs_n,
    input ready_irq, wait_n, wait_oe, dmarq, dmarq_oe, vs1_n, vs1_oe, vs2_oe, data_oe
  );
endinterface : card_port_if

// ### sync2.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  // Only the second stage is visible outside
  always_comb
  begin
    d = q;
    d.meta = d_i;
    d.stable = q.meta;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      q <= {INIT, INIT};
    end
    else
    begin
      q <= d;
    end
  end

  assign q_o = q.stable;
endmodule : sync2

// ### card_end.sv
// Card end of the host port: mode, reset, ready/interrupt, wait and DMA handshake
`timescale 1ns/10ps

// What this block does
// - Memory mode: output enable reads any space
// - I/O mode: output enable reads attribute only
// - Host grounds output enable for IDE
// - Memory mode READY high when idle, low busy
// - READY low until reset processing finishes
// - Host makes no access while busy
// - Reset held from power-up is disabled
// - I/O mode interrupt: pulse or level, low
// - IDE mode interrupt is active high
// - Attribute select high common, low attribute
// - Host holds attribute select low in I/O
// - Host acknowledges DMA request to transfer
// - Acknowledge ignored while no DMA active
// - Host without DMA holds acknowledge high
// - PC Card modes reset while pin high
// - Open or high pin: one initial reset
// - Soft reset bit also resets the card
// - IDE mode reset pin is active low
// - First voltage sense grounded, second open
// - PC Card modes stretch cycles with wait
// - IDE outside Ultra DMA: wait is IORDY
// - Request drops after acknowledge, returns if more
// - DMA direction by strobes, selects negated
module card_end (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Host pins
  card_port_if.card pins,
  // Back end status
  input wire logic busy_i,
  input wire logic io_cfg_i,
  input wire logic soft_rst_i,
  input wire logic wait_req_i,
  input wire logic udma_i,
  // Interrupt source
  input wire logic irq_i,
  input wire logic irq_pulse_i,
  // DMA source
  input wire logic dma_req_i,
  // Decoded access
  output card_pkg::mode_t mode_o,
  output card_pkg::space_t space_o,
  output logic dma_ack_o,
  output logic card_rst_o
);
  import card_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [6:0] raw;
  logic [6:0] sync;
  logic oe_s;
  logic reg_s;
  logic dmack_s;
  logic iord_s;
  logic iowr_s;
  logic we_s;
  logic rst_s;

  assign raw = {pins.oe_n, pins.reg_n, pins.dmack_n, pins.iord_n, pins.iowr_n,
                pins.we_n, pins.rst_pin};

  sync2 #(
    .W(7),
    .INIT(CARD_SYNC_INIT)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .d_i(raw),
    .q_o(sync)
  );

  assign {oe_s, reg_s, dmack_s, iord_s, iowr_s, we_s, rst_s} = sync;

  // ==========================================================
  // State
  card_state_t q;
  card_state_t d;
  logic pin_act;
  logic rst_req;
  logic running;
  logic cycle;
  logic ireq_on;
  mode_t mode;

  always_comb
  begin
    d = q;
    pin_act = q.ide ? !rst_s : rst_s;
    // Pin reset only counts once the pin has been seen released
    rst_req = (q.armed && pin_act) || soft_rst_i;

    // Reset sequencing: READY stays busy in every state but RS_RUN
    case (q.rst)
      RS_POWER:
      begin
        d.ide = !oe_s;
        d.rst_cnt = q.rst_cnt + 1'b1;
        if (q.rst_cnt == CNT_W'(RESET_CYCLES - 1))
        begin
          d.rst = RS_RUN;
        end
      end
      RS_RUN:
      begin
        if (rst_req)
        begin
          d.rst = RS_HELD;
        end
      end
      RS_HELD:
      begin
        d.rst_cnt = '0;
        if (!rst_req)
        begin
          d.rst = RS_BUSY;
        end
      end
      RS_BUSY:
      begin
        d.rst_cnt = q.rst_cnt + 1'b1;
        if (rst_req)
        begin
          d.rst = RS_HELD;
        end
        else if (q.rst_cnt == CNT_W'(RESET_CYCLES - 1))
        begin
          d.rst = RS_RUN;
        end
      end
      default:
      begin
        d.rst = RS_POWER;
      end
    endcase
    if (q.rst != RS_POWER && !pin_act)
    begin
      d.armed = 1'b1;
    end

    running = (q.rst == RS_RUN);
    d.card_rst = (d.rst != RS_RUN);
    mode = q.ide ? MODE_IDE : (io_cfg_i ? MODE_IO : MODE_MEM);
    d.mode = mode;
    cycle = !oe_s || !we_s || !iord_s || !iowr_s;

    // Space decode and data bus drive
    d.space = SPACE_NONE;
    d.data_oe = 1'b0;
    if (running)
    begin
      case (mode)
        MODE_MEM:
        begin
          if (!oe_s || !we_s)
          begin
            d.space = reg_s ? SPACE_COMMON : SPACE_ATTR;
          end
          d.data_oe = !oe_s;
        end
        MODE_IO:
        begin
          if (!reg_s && (!iord_s || !iowr_s))
          begin
            d.space = SPACE_IO;
          end
          else if (!reg_s && (!oe_s || !we_s))
          begin
            d.space = SPACE_ATTR;
          end
          // Output enable with common space selected is not an I/O read
          d.data_oe = !reg_s && (!oe_s || !iord_s);
        end
        MODE_IDE:
        begin
          if (!iord_s || !iowr_s)
          begin
            d.space = SPACE_IO;
          end
          d.data_oe = !iord_s;
        end
        default:
        begin
          d.space = SPACE_NONE;
        end
      endcase
    end

    // Interrupt pulse stretcher
    d.irq_prev = irq_i;
    if (irq_i && !q.irq_prev)
    begin
      d.ireq_cnt = CNT_W'(IREQ_PULSE_CYCLES);
    end
    else if (q.ireq_cnt != '0)
    begin
      d.ireq_cnt = q.ireq_cnt - 1'b1;
    end
    ireq_on = irq_pulse_i ? (q.ireq_cnt != '0) : irq_i;

    // Shared ready / interrupt pin
    case (mode)
      MODE_MEM: d.ready_irq = running && !busy_i;
      MODE_IO: d.ready_irq = !(running && ireq_on);
      MODE_IDE: d.ready_irq = running && irq_i;
      default: d.ready_irq = 1'b0;
    endcase

    // Wait / IORDY
    if (mode == MODE_IDE)
    begin
      // Ultra DMA takes the pin over, so it is released here
      d.wait_oe = !udma_i;
      d.wait_n = !wait_req_i;
    end
    else
    begin
      d.wait_oe = 1'b1;
      d.wait_n = !(running && cycle && wait_req_i);
    end

    // DMA handshake, only meaningful in IDE mode
    if (!running || mode != MODE_IDE)
    begin
      d.dma = DMA_IDLE;
    end
    else
    begin
      case (q.dma)
        DMA_IDLE:
        begin
          // Acknowledge is not looked at here, even if floating
          if (dma_req_i)
          begin
            d.dma = DMA_REQ;
          end
        end
        DMA_REQ:
        begin
          if (!dmack_s)
          begin
            d.dma = DMA_ACK;
          end
        end
        DMA_ACK:
        begin
          if (dmack_s)
          begin
            d.dma = dma_req_i ? DMA_REQ : DMA_IDLE;
          end
        end
        default:
        begin
          d.dma = DMA_IDLE;
        end
      endcase
    end
    d.dmarq = (d.dma == DMA_REQ);
    d.dmarq_oe = (mode == MODE_IDE);
    d.dma_ack = (d.dma == DMA_ACK);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      q <= CARD_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign pins.ready_irq = q.ready_irq;
  assign pins.wait_n = q.wait_n;
  assign pins.wait_oe = q.wait_oe;
  assign pins.dmarq = q.dmarq;
  assign pins.dmarq_oe = q.dmarq_oe;
  assign pins.data_oe = q.data_oe;
  // Voltage sense: first one a fixed low, second never driven
  assign pins.vs1_n = 1'b0;
  assign pins.vs1_oe = 1'b1;
  assign pins.vs2_oe = 1'b0;
  assign mode_o = q.mode;
  assign space_o = q.space;
  assign dma_ack_o = q.dma_ack;
  assign card_rst_o = q.card_rst;
endmodule : card_end

// ### host_end.sv
// Host end of the card port: access cycles, reset pin and DMA acknowledge
`timescale 1ns/10ps
module host_end (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Card pins
  card_port_if.host pins,
  // Configuration
  input card_pkg::mode_t mode_i,
  input wire logic dma_en_i,
  input wire logic dma_wr_i,
  input wire logic rst_req_i,
  // Command port
  input wire logic cmd_valid_i,
  input card_pkg::cmd_t cmd_i,
  output logic cmd_ready_o,
  output logic cmd_done_o,
  output logic dma_busy_o
);
  import card_pkg::*;

  // ==========================================================
  // Card output synchronisers
  logic [2:0] sync;
  logic ready_s;
  logic wait_s;
  logic dmarq_s;

  sync2 #(
    .W(3),
    .INIT(HOST_SYNC_INIT)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .d_i({pins.ready_irq, pins.wait_n, pins.dmarq}),
    .q_o(sync)
  );

  assign {ready_s, wait_s, dmarq_s} = sync;

  // ==========================================================
  // Cycle engine
  host_state_st_t q;
  host_state_st_t d;
  logic blocked;
  logic is_ide;
  logic dma_go;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    is_ide = (mode_i == MODE_IDE);
    // No access while the card reports busy in memory mode
    blocked = rst_req_i || (mode_i == MODE_MEM && !ready_s);
    dma_go = is_ide && dma_en_i && dmarq_s;
    d.rst_pin = is_ide ? !rst_req_i : rst_req_i;
    case (q.hs)
      H_IDLE:
      begin
        d.oe_n = !is_ide;
        d.cnt = '0;
        if (cmd_valid_i && q.cmd_ready)
        begin
          d.hs = H_STROBE;
          d.reg_n = (cmd_i == CMD_MEM_RD || cmd_i == CMD_MEM_WR);
          if (is_ide)
          begin
            d.cs_n = CS_SEL0;
          end
          case (cmd_i)
            CMD_MEM_RD, CMD_ATTR_RD: d.oe_n = 1'b0;
            CMD_MEM_WR, CMD_ATTR_WR: d.we_n = 1'b0;
            CMD_IO_RD: d.iord_n = 1'b0;
            CMD_IO_WR: d.iowr_n = 1'b0;
            default: d.hs = H_IDLE;
          endcase
        end
        else if (dma_go)
        begin
          // Word transfers with both chip selects kept negated
          d.hs = H_STROBE;
          d.dma_busy = 1'b1;
          d.dmack_n = 1'b0;
          d.cs_n = CS_IDLE;
          d.iowr_n = !dma_wr_i;
          d.iord_n = dma_wr_i;
        end
      end
      H_STROBE:
      begin
        d.cnt = q.cnt + 1'b1;
        // The card only sees the strobe a few cycles late, so a minimum width
        // is kept before wait is trusted
        if (q.cnt >= CNT_W'(STROBE_CYCLES - 1) && wait_s)
        begin
          d.hs = H_RECOV;
          d.cnt = '0;
          d.done = 1'b1;
          d.oe_n = !is_ide;
          d.we_n = 1'b1;
          d.iord_n = 1'b1;
          d.iowr_n = 1'b1;
        end
      end
      H_RECOV:
      begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == CNT_W'(RECOV_CYCLES - 1))
        begin
          d.hs = H_IDLE;
          d.reg_n = 1'b1;
          d.cs_n = CS_IDLE;
          d.dmack_n = 1'b1;
          d.dma_busy = 1'b0;
        end
      end
      default:
      begin
        d.hs = H_IDLE;
      end
    endcase
    d.cmd_ready = (d.hs == H_IDLE) && !blocked && !dma_go;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      q <= HOST_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign pins.oe_n = q.oe_n;
  assign pins.reg_n = q.reg_n;
  assign pins.we_n = q.we_n;
  assign pins.iord_n = q.iord_n;
  assign pins.iowr_n = q.iowr_n;
  assign pins.dmack_n = q.dmack_n;
  assign pins.rst_pin = q.rst_pin;
  assign pins.cs_n = q.cs_n;
  assign cmd_ready_o = q.cmd_ready;
  assign cmd_done_o = q.done;
  assign dma_busy_o = q.dma_busy;
endmodule : host_end

// ### card_port_props.sv
// Pin-level temporal checks between the card end and the host end
`timescale 1ns/10ps
module card_port_props
  import card_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Host driven pins
  input wire logic oe_n,
  input wire logic reg_n,
  input wire logic we_n,
  input wire logic iord_n,
  input wire logic iowr_n,
  input wire logic dmack_n,
  input wire logic [1:0] cs_n,
  // Card driven pins
  input wire logic wait_n,
  input wire logic wait_oe,
  input wire logic dmarq,
  input wire logic dmarq_oe,
  input wire logic vs1_n,
  input wire logic vs1_oe,
  input wire logic vs2_oe,
  input wire logic data_oe
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  // ==========================================================
  // Assertions
  AST_VS_FIXED: assert property (!vs1_n && vs1_oe && !vs2_oe)
    else $error("voltage sense pins wrong");
  // Three cycles of pin lag, so only a settled idle bus is judged
  AST_NO_READ_DATA: assert property ((oe_n && iord_n)[*4] |-> !data_oe)
    else $error("data driven without a read strobe");
  AST_DMARQ_DROP: assert property ((dmarq_oe && !dmack_n)[*4] |-> !dmarq)
    else $error("request held after acknowledge");
  AST_ACK_AFTER_REQ: assert property ($fell(dmack_n) |-> $past(dmarq, 2))
    else $error("acknowledge without request");
  AST_DMA_CS_IDLE: assert property (!dmack_n |-> cs_n == CS_IDLE)
    else $error("chip select active during DMA");
  AST_ONE_STROBE: assert property (!(!iord_n && !iowr_n))
    else $error("both I/O strobes low");
  AST_IO_REG_LOW: assert property ((!iord_n || !iowr_n) && dmack_n |-> !reg_n)
    else $error("attribute select high in an I/O cycle");
  AST_ACK_WITH_STROBE: assert property ($fell(dmack_n) |-> ##[0:1] (!iord_n || !iowr_n))
    else $error("acknowledge without a direction strobe");
  AST_WAIT_HOLDS: assert property (wait_oe && ($rose(oe_n) || $rose(we_n) || $rose(iord_n)
    || $rose(iowr_n)) |-> $past(wait_n, 3))
    else $error("strobe released while wait low");

  cover property ($fell(dmack_n));
  cover property ($fell(wait_n) && wait_oe);
  cover property ($rose(data_oe));
endmodule : card_port_props

// ### card_host_interface_control_bench.sv
// Self-checking bench joining the card end and the host end
`timescale 1ns/10ps
module card_host_interface_control_bench;
  import card_pkg::*;
  // ==========================================================
  // Signals
  typedef struct packed {logic io; cmd_t c; space_t sp; logic doe;} row_t;
  logic clk_sys_i, srst_i = 1'h1, busy_i = 1'h0, io_cfg_i = 1'h0, soft_rst_i = 1'h0;
  logic wait_req_i = 1'h0, udma_i = 1'h0, irq_i = 1'h0, irq_pulse_i = 1'h0;
  logic dma_req_i = 1'h0, dma_en_i = 1'h0, dma_wr_i = 1'h0, rst_req_i = 1'h1;
  logic cmd_valid_i = 1'h0, cmd_ready_o, cmd_done_o, dma_busy_o, dma_ack_o, card_rst_o;
  logic doe, wt;
  mode_t mode_i = MODE_MEM;
  mode_t mode_o;
  cmd_t cmd_i = CMD_MEM_RD;
  space_t space_o, sp;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  row_t rows [8] = '{'{1'h0, CMD_MEM_RD, SPACE_COMMON, 1'h1},
    '{1'h0, CMD_ATTR_RD, SPACE_ATTR, 1'h1}, '{1'h0, CMD_MEM_WR, SPACE_COMMON, 1'h0},
    '{1'h0, CMD_ATTR_WR, SPACE_ATTR, 1'h0}, '{1'h1, CMD_IO_RD, SPACE_IO, 1'h1},
    '{1'h1, CMD_IO_WR, SPACE_IO, 1'h0}, '{1'h1, CMD_ATTR_RD, SPACE_ATTR, 1'h1},
    '{1'h1, CMD_MEM_RD, SPACE_NONE, 1'h0}};

  card_port_if pins ();
  card_end u_card_end (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .pins(pins),
    .busy_i(busy_i), .io_cfg_i(io_cfg_i), .soft_rst_i(soft_rst_i), .wait_req_i(wait_req_i),
    .udma_i(udma_i), .irq_i(irq_i), .irq_pulse_i(irq_pulse_i), .dma_req_i(dma_req_i),
    .mode_o(mode_o), .space_o(space_o), .dma_ack_o(dma_ack_o), .card_rst_o(card_rst_o));
  host_end u_host_end (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .pins(pins),
    .mode_i(mode_i), .dma_en_i(dma_en_i), .dma_wr_i(dma_wr_i), .rst_req_i(rst_req_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
    .cmd_done_o(cmd_done_o), .dma_busy_o(dma_busy_o));
  card_port_props u_card_port_props (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .oe_n(pins.oe_n), .reg_n(pins.reg_n), .we_n(pins.we_n), .iord_n(pins.iord_n),
    .iowr_n(pins.iowr_n),
    .dmack_n(pins.dmack_n), .cs_n(pins.cs_n), .wait_n(pins.wait_n), .wait_oe(pins.wait_oe),
    .dmarq(pins.dmarq), .dmarq_oe(pins.dmarq_oe), .vs1_n(pins.vs1_n),
    .vs1_oe(pins.vs1_oe), .vs2_oe(pins.vs2_oe), .data_oe(pins.data_oe));

  initial
  begin
    clk_sys_i = 1'h0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // ==========================================================
  // Tasks
  task automatic note(input string what, input string e, input string g, input logic ok);
    checked++;
    if (!ok)
    begin
      failures++;
      $display("BAD %s expected %s seen %s", what, e, g);
    end
  endtask : note

  task automatic chk_bit(input string what, input logic e, input logic g);
    note(what, $sformatf("%b", e), $sformatf("%b", g), g === e);
  endtask : chk_bit

  task automatic chk_space(input string what, input space_t e, input space_t g);
    note(what, $sformatf("%0d", e), $sformatf("%0d", g), g === e);
  endtask : chk_space

  task automatic chk_mode(input string what, input mode_t e, input mode_t g);
    note(what, $sformatf("%0d", e), $sformatf("%0d", g), g === e);
  endtask : chk_mode

  task automatic chk_num(input string what, input int e, input int g);
    note(what, $sformatf("%0d", e), $sformatf("%0d", g), g == e);
  endtask : chk_num

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask : cyc

  task automatic wait_sig(input string what, ref logic s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && s !== v; i++)
      @(posedge clk_sys_i);
    chk_bit(what, v, s);
  endtask : wait_sig

  // Counts the cycles in which the shared ready/interrupt pin shows v
  task automatic count_lvl(input logic v, input int len, output int k);
    k = 0;
    repeat (len)
    begin
      @(posedge clk_sys_i);
      if (pins.ready_irq === v)
        k++;
    end
  endtask : count_lvl

  // One host command; snapshot mid-strobe, optional wait release at cycle rel
  task automatic run_cmd(input cmd_t c, input int rel, output int k);
    wait_sig("cmd_ready", cmd_ready_o, 1'h1, 300);
    cmd_valid_i <= 1'h1;
    cmd_i <= c;
    @(posedge clk_sys_i);
    // Request stands until the edge that sees ready high takes it
    while (cmd_ready_o !== 1'h1)
      @(posedge clk_sys_i);
    cmd_valid_i <= 1'h0;
    k = 0;
    while (cmd_done_o !== 1'h1 && k < 400)
    begin
      @(posedge clk_sys_i);
      k++;
      if (k == 12)
      begin
        sp = space_o;
        doe = pins.data_oe;
        wt = pins.wait_n;
      end
      if (k == rel)
        wait_req_i <= 1'h0;
    end
    chk_bit("cmd_done", 1'h1, cmd_done_o);
    cyc(14);
  endtask : run_cmd

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Ceiling well above the roughly 1500 cycles the sequence needs
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      complete_run();
    end
  end

  // ==========================================================
  // Sequence
  initial
  begin
    cyc(10);
    srst_i <= 1'h0;
    // Reset pin held active from power-up must not keep the card busy
    count_lvl(1'h0, 120, n);
    chk_num("ready low at power-up", 120, n);
    wait_sig("ready", pins.ready_irq, 1'h1, 60);
    chk_bit("card_rst", 1'h0, card_rst_o);
    rst_req_i <= 1'h0;
    cyc(4);
    foreach (rows[i])
    begin
      io_cfg_i <= rows[i].io;
      mode_i <= rows[i].io ? MODE_IO : MODE_MEM;
      cyc(6);
      chk_mode("mode", rows[i].io ? MODE_IO : MODE_MEM, mode_o);
      run_cmd(rows[i].c, 0, n);
      chk_space("space", rows[i].sp, sp);
      chk_bit("data_oe", rows[i].doe, doe);
      chk_bit("strobe length", 1'h1, n >= STROBE_CYCLES);
    end
    io_cfg_i <= 1'h0;
    mode_i <= MODE_MEM;
    busy_i <= 1'h1;
    cyc(6);
    chk_bit("ready busy", 1'h0, pins.ready_irq);
    chk_bit("cmd_ready busy", 1'h0, cmd_ready_o);
    busy_i <= 1'h0;
    wait_sig("ready idle", pins.ready_irq, 1'h1, 10);
    wait_req_i <= 1'h1;
    run_cmd(CMD_MEM_RD, 60, n);
    chk_bit("wait low", 1'h0, wt);
    chk_bit("stretched", 1'h1, n > 60);
    rst_req_i <= 1'h1;
    cyc(8);
    chk_bit("pin reset", 1'h1, card_rst_o);
    chk_bit("ready in reset", 1'h0, pins.ready_irq);
    rst_req_i <= 1'h0;
    cyc(110);
    chk_bit("reset busy", 1'h1, card_rst_o);
    wait_sig("reset done", card_rst_o, 1'h0, 60);
    soft_rst_i <= 1'h1;
    cyc(4);
    chk_bit("soft reset", 1'h1, card_rst_o);
    soft_rst_i <= 1'h0;
    wait_sig("soft done", card_rst_o, 1'h0, 200);
    io_cfg_i <= 1'h1;
    irq_pulse_i <= 1'h1;
    cyc(6);
    irq_i <= 1'h1;
    count_lvl(1'h0, 100, n);
    chk_num("pulse length", IREQ_PULSE_CYCLES, n);
    irq_i <= 1'h0;
    irq_pulse_i <= 1'h0;
    cyc(4);
    irq_i <= 1'h1;
    cyc(70);
    chk_bit("level irq", 1'h0, pins.ready_irq);
    irq_i <= 1'h0;
    cyc(4);
    chk_bit("irq clear", 1'h1, pins.ready_irq);
    io_cfg_i <= 1'h0;
    mode_i <= MODE_IDE;
    srst_i <= 1'h1;
    cyc(10);
    srst_i <= 1'h0;
    cyc(5);
    chk_bit("select pin", 1'h0, pins.oe_n);
    wait_sig("ide up", card_rst_o, 1'h0, 200);
    chk_mode("mode", MODE_IDE, mode_o);
    chk_bit("dmarq driven", 1'h1, pins.dmarq_oe);
    irq_i <= 1'h1;
    cyc(4);
    chk_bit("intrq", 1'h1, pins.ready_irq);
    irq_i <= 1'h0;
    cyc(4);
    chk_bit("intrq clear", 1'h0, pins.ready_irq);
    udma_i <= 1'h1;
    cyc(3);
    chk_bit("iordy off", 1'h0, pins.wait_oe);
    udma_i <= 1'h0;
    cyc(3);
    chk_bit("iordy on", 1'h1, pins.wait_oe);
    wait_req_i <= 1'h1;
    run_cmd(CMD_IO_RD, 40, n);
    chk_bit("iordy low", 1'h0, wt);
    chk_bit("iordy stretch", 1'h1, n > 40);
    chk_space("ide space", SPACE_IO, sp);
    chk_bit("ide read data", 1'h1, doe);
    dma_en_i <= 1'h1;
    for (int d = 0; d < 2; d++)
    begin
      dma_wr_i <= d[0];
      dma_req_i <= 1'h1;
      wait_sig("dma ack", dma_ack_o, 1'h1, 60);
      chk_bit("dma busy", 1'h1, dma_busy_o);
      dma_req_i <= 1'h0;
      wait_sig("dma end", dma_busy_o, 1'h0, 100);
      cyc(6);
      chk_bit("dmarq idle", 1'h0, pins.dmarq);
    end
    rst_req_i <= 1'h1;
    cyc(6);
    chk_bit("ide reset pin", 1'h0, pins.rst_pin);
    chk_bit("ide reset", 1'h1, card_rst_o);
    rst_req_i <= 1'h0;
    wait_sig("ide reset done", card_rst_o, 1'h0, 200);
    complete_run();
  end
endmodule : card_host_interface_control_bench
